// ===== rxfs_consts.svh
`ifndef RXFS_CONSTS_SVH
`define RXFS_CONSTS_SVH
// Register offsets (config is write side, frame status is read side)
`define RXFS_ADDR_CFG 8'h0c
`define RXFS_ADDR_INT_STAT 8'h10
`define RXFS_ADDR_INT_MASK 8'h14
`define RXFS_ADDR_TALLY_ALIGN 8'h18
`define RXFS_ADDR_TALLY_CRC 8'h1c
`define RXFS_ADDR_TALLY_DROP 8'h20
// Configuration fields
`define RXFS_CFG_KEEP_BAD 0
`define RXFS_CFG_SHORT 1
`define RXFS_CFG_ALL_ONES 2
`define RXFS_CFG_GROUP 3
`define RXFS_CFG_ANY_UNI 4
`define RXFS_CFG_CHECK_ONLY 5
// Status fields
`define RXFS_ST_OK 0
`define RXFS_ST_CRC 1
`define RXFS_ST_ALIGN 2
`define RXFS_ST_OVF 3
`define RXFS_ST_DROP 4
`define RXFS_ST_GROUP 5
`define RXFS_ST_HALT 6
`define RXFS_ST_BUSY 7
// Frame lengths in bytes
`define RXFS_MIN_LEN 16'h0040
`define RXFS_RUNT_LEN 16'h0008
// Index of the last destination byte; beyond it the address is complete
`define RXFS_ADDR_LAST 16'h0005
// Interrupt event bits
`define RXFS_IRQ_ACCEPT 0
`define RXFS_IRQ_ERROR 1
`define RXFS_IRQ_DROP 2
`define RXFS_IRQ_OVF 3
`endif

// ===== rxfs_pkg.sv
package rxfs_pkg;
  typedef enum logic [1:0] {RXFS_IDLE, RXFS_ADDR, RXFS_BODY, RXFS_DONE} rxfs_state_e;
  typedef logic [7:0] rxfs_byte_t;
endpackage

// ===== rxfs_top.sv
`timescale 1ns/100ps
`include "rxfs_consts.svh"
// Notes on behaviour
// - Errored frames kept only when keep bit set
// - Short frames need bit and eight bytes
// - All-ones destination needs its accept bit
// - Broadcast and group acceptance kept apart; group hash never admits all-ones
// - Unicast matches station address unless any-unicast
// - Check-only mode checks, never buffers, counts drops
// - Status written for good or kept errored
// - Status cleared when next frame arrives
// - Intact only when all error bits zero
// - Bad checksum sets flag and counts tally
// - Misaligned bad checksum sets flag, counts tally
// - Overflow sets flag and aborts the frame
// - Dropped frame sets flag and counts tally
// - Group flag one for group destinations, zero for any unicast
// - Halted flag follows check-only mode or receive disable
// - Busy flag follows carrier or clash lines
// - Misalign without checksum error never produced
module rxfs_top #(
  parameter int TALLY_W = 8,
  parameter int LEN_W = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  output logic irq,
  input wire logic [47:0] station_addr_bytes,
  input wire logic hash_hit,
  input wire logic carrier_sense_in,
  input wire logic clash_detect_line,
  input wire logic frame_start,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic frame_end,
  input wire logic crc_bad,
  input wire logic odd_bits,
  input wire logic fifo_overflow,
  input wire logic buffers_full,
  input wire logic rx_enable,
  output logic frame_abort,
  output logic frame_flush,
  output logic status_write,
  output logic [7:0] status_byte,
  output logic buffer_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for the transceiver sense lines
  logic crs_s1;
  logic crs_s2;
  logic cd_s1;
  logic cd_s2;
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      crs_s1 <= 1'b0;
      crs_s2 <= 1'b0;
      cd_s1 <= 1'b0;
      cd_s2 <= 1'b0;
    end
    else if (clk_en)
    begin
      crs_s1 <= carrier_sense_in;
      crs_s2 <= crs_s1;
      cd_s1 <= clash_detect_line;
      cd_s2 <= cd_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [5:0] rx_filter_config;
  logic [7:0] rx_frame_status;
  logic [3:0] int_stat;
  logic [3:0] int_mask;
  logic [TALLY_W-1:0] misalign_tally;
  logic [TALLY_W-1:0] checksum_error_tally;
  logic [TALLY_W-1:0] dropped_tally;

  wire keep_bad_frames = rx_filter_config[`RXFS_CFG_KEEP_BAD];
  wire accept_short_frames = rx_filter_config[`RXFS_CFG_SHORT];
  wire accept_all_ones_dest = rx_filter_config[`RXFS_CFG_ALL_ONES];
  wire accept_group_hashed = rx_filter_config[`RXFS_CFG_GROUP];
  wire accept_any_unicast = rx_filter_config[`RXFS_CFG_ANY_UNI];
  wire check_only_mode = rx_filter_config[`RXFS_CFG_CHECK_ONLY];

  wire wr_cfg = bus_wr && (bus_addr == `RXFS_ADDR_CFG);
  wire wr_mask = bus_wr && (bus_addr == `RXFS_ADDR_INT_MASK);
  wire rd_istat = bus_rd && (bus_addr == `RXFS_ADDR_INT_STAT);

  // Configuration and mask writes; reserved config bits are dropped
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rx_filter_config <= 6'h00;
      int_mask <= 4'h0;
    end
    else if (clk_en)
    begin
      if (wr_cfg)
        rx_filter_config <= bus_wdata[5:0];
      if (wr_mask)
        int_mask <= bus_wdata[3:0];
    end
  end

  // Read mux, registered so data lands the cycle after the strobe
  logic [7:0] next_rdata;
  always_comb
  begin
    next_rdata = 8'h00;
    case (bus_addr)
      `RXFS_ADDR_CFG: next_rdata = rx_frame_status;
      `RXFS_ADDR_INT_STAT: next_rdata = {4'h0, int_stat};
      `RXFS_ADDR_INT_MASK: next_rdata = {4'h0, int_mask};
      `RXFS_ADDR_TALLY_ALIGN: next_rdata = 8'(misalign_tally);
      `RXFS_ADDR_TALLY_CRC: next_rdata = 8'(checksum_error_tally);
      `RXFS_ADDR_TALLY_DROP: next_rdata = 8'(dropped_tally);
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      bus_rdata <= 8'h00;
    else if (clk_en)
      bus_rdata <= bus_rd ? next_rdata : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Destination address capture and frame tracking
  rxfs_pkg::rxfs_state_e state;
  rxfs_pkg::rxfs_state_e next_state;
  logic [47:0] dest;
  logic [LEN_W-1:0] len;
  logic ovf_seen;

  wire byte_in = rx_byte_valid && (state == rxfs_pkg::RXFS_ADDR
    || state == rxfs_pkg::RXFS_BODY);
  wire addr_full = (len == LEN_W'(`RXFS_ADDR_LAST)) && byte_in;

  always_comb
  begin
    next_state = state;
    case (state)
      rxfs_pkg::RXFS_IDLE: if (frame_start) next_state = rxfs_pkg::RXFS_ADDR;
      rxfs_pkg::RXFS_ADDR:
        if (frame_end || ovf_seen) next_state = rxfs_pkg::RXFS_DONE;
        else if (addr_full) next_state = rxfs_pkg::RXFS_BODY;
      rxfs_pkg::RXFS_BODY:
        if (frame_end || ovf_seen) next_state = rxfs_pkg::RXFS_DONE;
      rxfs_pkg::RXFS_DONE: next_state = rxfs_pkg::RXFS_IDLE;
      default: next_state = rxfs_pkg::RXFS_IDLE;
    endcase
  end

  // Destination bytes arrive first, least significant byte first
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state <= rxfs_pkg::RXFS_IDLE;
      dest <= 48'h0;
      len <= '0;
      ovf_seen <= 1'b0;
    end
    else if (clk_en)
    begin
      state <= next_state;
      if (frame_start && state == rxfs_pkg::RXFS_IDLE)
      begin
        len <= '0;
        ovf_seen <= 1'b0;
      end
      else
      begin
        if (byte_in && len != '1)
          len <= len + LEN_W'(1);
        if (byte_in && state == rxfs_pkg::RXFS_ADDR)
          dest <= {rx_byte, dest[47:8]};
        if (fifo_overflow && state != rxfs_pkg::RXFS_IDLE)
          ovf_seen <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance decision
  wire is_group = dest[0];
  wire is_all_ones = (dest == 48'hffff_ffff_ffff);
  wire ones_ok = is_all_ones && accept_all_ones_dest;
  wire hash_ok = is_group && !is_all_ones && accept_group_hashed && hash_hit;
  wire uni_ok = !is_group && (accept_any_unicast || dest == station_addr_bytes);
  wire addr_ok = ones_ok || hash_ok || uni_ok;
  // Done cycle still knows the address was complete through the byte count
  wire addr_done = (state == rxfs_pkg::RXFS_BODY)
    || (state == rxfs_pkg::RXFS_DONE && len > LEN_W'(`RXFS_ADDR_LAST));
  wire len_short = len < LEN_W'(`RXFS_MIN_LEN);
  wire len_ok = !len_short || (accept_short_frames && len >= LEN_W'(`RXFS_RUNT_LEN));
  wire err_crc = crc_bad || odd_bits;
  wire err_align = odd_bits && crc_bad;
  wire err_any = err_crc;
  wire fin = (state == rxfs_pkg::RXFS_DONE);
  wire addressed = fin && addr_done && addr_ok;
  wire recognised = addressed && !ovf_seen;
  wire dropped = recognised && (check_only_mode || buffers_full);
  wire kept = recognised && !dropped && len_ok && (!err_any || keep_bad_frames);

  // Early flush of unwanted frames; check-only never reaches memory
  assign frame_flush = (addr_done && !addr_ok) || fin && !kept;
  assign frame_abort = ovf_seen;
  assign buffer_en = addr_done && addr_ok && !check_only_mode && !buffers_full;

  ////////////////////////////////////////////////////////////////////////////
  // Frame status, written out for kept frames only
  wire busy = crs_s2 || cd_s2;
  wire halt = check_only_mode || !rx_enable;
  logic [5:0] frame_bits;
  wire [5:0] next_frame_bits = {addr_done && is_group, dropped, ovf_seen,
    err_align && !ovf_seen, err_crc && !ovf_seen,
    !err_any && !ovf_seen && !dropped};

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      frame_bits <= 6'h00;
      status_write <= 1'b0;
      status_byte <= 8'h00;
    end
    else if (clk_en)
    begin
      if (frame_start && state == rxfs_pkg::RXFS_IDLE)
        frame_bits <= 6'h00;
      else if (addressed)
        frame_bits <= next_frame_bits;
      status_write <= kept;
      if (kept)
        status_byte <= {busy, halt, next_frame_bits};
    end
  end

  assign rx_frame_status = {busy, halt, frame_bits};

  ////////////////////////////////////////////////////////////////////////////
  // Tally counters saturate so a slow reader never sees a wrap
  wire inc_align = fin && recognised && err_align;
  wire inc_crc = fin && recognised && err_crc;
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      misalign_tally <= '0;
      checksum_error_tally <= '0;
      dropped_tally <= '0;
    end
    else if (clk_en)
    begin
      if (inc_align && misalign_tally != '1)
        misalign_tally <= misalign_tally + TALLY_W'(1);
      if (inc_crc && checksum_error_tally != '1)
        checksum_error_tally <= checksum_error_tally + TALLY_W'(1);
      if (dropped && dropped_tally != '1)
        dropped_tally <= dropped_tally + TALLY_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky events, read clears, a new event wins
  wire [3:0] ev;
  assign ev[`RXFS_IRQ_ACCEPT] = kept;
  assign ev[`RXFS_IRQ_ERROR] = inc_crc;
  assign ev[`RXFS_IRQ_DROP] = dropped;
  assign ev[`RXFS_IRQ_OVF] = fin && ovf_seen;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      int_stat <= 4'h0;
    else if (clk_en)
      int_stat <= (rd_istat ? 4'h0 : int_stat) | ev;
  end

  assign irq = |(int_stat & int_mask);

endmodule

// ===== rxfs_link_model.sv
`timescale 1ns/100ps
// Stand-in for the serial front end: one frame per send call
module rxfs_link_model (
  input wire logic clk_sys,
  output logic frame_start,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic frame_end,
  output logic crc_bad,
  output logic odd_bits,
  output logic fifo_overflow
);
  initial
  begin
    {frame_start, rx_byte_valid, frame_end, crc_bad, odd_bits, fifo_overflow} = '0;
    rx_byte = 8'h00;
  end
  ////////////////////////////////////////////////////////////////
  // Dest goes least significant byte first; idle data is inverted junk
  task automatic send(input logic [47:0] d, input int len, input logic crc,
    input logic odd, input logic ovf);
    @(posedge clk_sys) frame_start <= 1'b1;
    for (int i = 0; i < len; i++)
    begin
      @(posedge clk_sys);
      frame_start <= 1'b0;
      rx_byte_valid <= 1'b1;
      rx_byte <= (i < 6) ? d[8*i +: 8] : 8'($urandom);
      fifo_overflow <= ovf && (i == 10);
    end
    @(posedge clk_sys);
    rx_byte_valid <= 1'b0;
    rx_byte <= ~rx_byte;
    frame_end <= 1'b1;
    crc_bad <= crc;
    odd_bits <= odd;
    // Gap covers the status pulse and the restart spacing
    @(posedge clk_sys) frame_end <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
endmodule

// ===== rxfs_sva.sv
`timescale 1ns/100ps
// Port-level checks of the status path
module rxfs_sva (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic frame_end,
  input wire logic crc_bad,
  input wire logic odd_bits,
  input wire logic fifo_overflow,
  input wire logic rx_byte_valid,
  input wire logic frame_abort,
  input wire logic status_write,
  input wire logic [7:0] status_byte
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Frame closes with a bad checksum, status lands two edges on
  sequence s_bad_end;
    frame_end && crc_bad ##2 status_write;
  endsequence
  sequence s_odd_end;
    frame_end && crc_bad && odd_bits ##2 status_write;
  endsequence
  AST_RDATA_IDLE: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
    else $error("read data outside its cycle");
  AST_WR_TIMING: assert property (status_write |-> $past(frame_end, 2))
    else $error("status write not two cycles after frame end");
  AST_WR_PULSE: assert property (status_write |=> !status_write)
    else $error("status write longer than one cycle");
  AST_OK_EXCL: assert property (status_write |-> !(status_byte[0] && |status_byte[4:1]))
    else $error("intact flag beside an error flag");
  AST_NO_CODE10: assert property (status_write |-> !(status_byte[2] && !status_byte[1]))
    else $error("misalign flag without checksum flag");
  AST_CRC_FLAG: assert property (s_bad_end |-> status_byte[1])
    else $error("checksum flag missing");
  AST_ALIGN_FLAG: assert property (s_odd_end |-> status_byte[2])
    else $error("misalign flag missing");
  AST_ABORT: assert property (rx_byte_valid && fifo_overflow |=> frame_abort)
    else $error("overflow did not abort frame");
endmodule
bind rxfs_top rxfs_sva chk (.clk_sys, .sys_rst, .bus_rd, .bus_rdata, .frame_end, .crc_bad,
  .odd_bits, .fifo_overflow, .rx_byte_valid, .frame_abort, .status_write, .status_byte);

// ===== tb_rx_filter_status.sv
`timescale 1ns/100ps
module tb_rx_filter_status;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] bus_addr = 8'h00, bus_wdata = 8'h00, bus_rdata, rx_byte, status_byte;
  logic bus_wr = 1'b0, bus_rd = 1'b0, irq, hash_hit = 1'b0, buffers_full = 1'b0;
  logic carrier_sense_in = 1'b0, clash_detect_line = 1'b0, rx_enable = 1'b1;
  logic frame_start, rx_byte_valid, frame_end, crc_bad, odd_bits, fifo_overflow;
  logic frame_abort, status_write;
  logic [47:0] stn = 48'h0a9876543210;
  int mismatches = 0, n_tests = 0, nsw = 0, t_crc = 0, t_al = 0, t_drop = 0;
  rxfs_top dut (.clk_sys, .sys_rst, .clk_en(1'b1), .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
    .bus_rdata, .irq, .station_addr_bytes(stn), .hash_hit, .carrier_sense_in,
    .clash_detect_line, .frame_start, .rx_byte_valid, .rx_byte, .frame_end, .crc_bad,
    .odd_bits, .fifo_overflow, .buffers_full, .rx_enable, .frame_abort, .frame_flush(),
    .status_write, .status_byte, .buffer_en());
  rxfs_link_model link (.clk_sys, .frame_start, .rx_byte_valid, .rx_byte, .frame_end,
    .crc_bad, .odd_bits, .fifo_overflow);
  initial forever #2 clk_sys = ~clk_sys;
  // Count status pulses so each frame can be judged kept or not
  always @(posedge clk_sys) if (status_write === 1'b1) nsw++;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk_sys) bus_wr <= 1'b0;
  endtask
  // Read data is looked at only in the cycle after the strobe
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk_sys) bus_rd <= 1'b0;
    #1 chk("rdata", e & m, bus_rdata & m);
  endtask
  // Bit 8 says written to memory; flags stay zero for a frame not addressed here
  function automatic logic [8:0] expect_frame(logic [5:0] c, logic [47:0] d, int len,
    logic crc, logic odd, logic ovf);
    logic hit, drop;
    hit = d[0] ? (&d ? c[2] : c[3] && hash_hit) : (c[4] || d == stn);
    drop = c[5] || buffers_full;
    return {hit && (len >= 64 || (c[1] && len >= 8)) && (!crc || c[0]) && !ovf && !drop,
      carrier_sense_in || clash_detect_line, c[5] || !rx_enable,
      {6{hit}} & {d[0], drop, ovf, odd, crc, !(crc || ovf || drop)}};
  endfunction
  task automatic run(input logic [5:0] c, input logic [47:0] d, input int len,
    input logic crc, input logic odd, input logic ovf, input logic [7:0] m);
    logic [8:0] e;
    int n0;
    wr(8'h0c, {2'b00, c});
    e = expect_frame(c, d, len, crc, odd, ovf);
    n0 = nsw;
    link.send(d, len, crc, odd, ovf);
    chk("status_write", {7'h00, e[8]}, 8'(nsw - n0));
    rdchk(8'h0c, e[7:0], m);
    t_crc += (|e[5:0] && crc && !ovf);
    t_al += (|e[5:0] && odd && !ovf);
    t_drop += (|e[5:0] && e[4] && !ovf);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Watchdog: the whole run needs well under 200 us
  initial
  begin
    #200000;
    mismatches++;
    test_done();
  end
  ////////////////////////////////////////////////////////////////
  initial
  begin
    logic [47:0] d;
    logic crc;
    void'($urandom(32'h6af6));
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rdchk(8'h30, 8'h00, 8'hff);
    wr(8'h0c, 8'h20);
    rdchk(8'h0c, 8'h40, 8'h40);
    wr(8'h14, 8'h01);
    rdchk(8'h10, 8'h00, 8'hff);
    run(6'h00, stn, 64, 1'b0, 1'b0, 1'b0, 8'h7f);
    chk("irq", 8'h01, {7'h00, irq});
    rdchk(8'h10, 8'h01, 8'h01);
    chk("irq", 8'h00, {7'h00, irq});
    wr(8'h14, 8'h00);
    run(6'h00, stn, 63, 1'b0, 1'b0, 1'b0, 8'h7f);
    run(6'h02, stn, 8, 1'b0, 1'b0, 1'b0, 8'h7f);
    run(6'h02, stn, 7, 1'b0, 1'b0, 1'b0, 8'h7f);
    run(6'h00, stn, 70, 1'b0, 1'b0, 1'b1, 8'h7f);
    chk("irq", 8'h00, {7'h00, irq});
    // Promiscuous setup: all three address accept bits and a hash that always hits
    hash_hit <= 1'b1;
    run(6'h1c, 48'h2300_005e_0001, 64, 1'b0, 1'b0, 1'b0, 8'h7f);
    // Random mix of modes, destinations and error kinds
    repeat (40)
    begin
      case ($urandom % 4)
        0: d = stn;
        1: d = '1;
        2: d = {16'($urandom), 32'($urandom)} | 48'h1;
        default: d = {16'($urandom), 32'($urandom)} & ~48'h1;
      endcase
      crc = 1'($urandom);
      hash_hit <= 1'($urandom);
      carrier_sense_in <= 1'($urandom);
      clash_detect_line <= 1'($urandom);
      buffers_full <= ($urandom % 4 == 0);
      run(6'($urandom), d, 64 + $urandom % 16, crc, crc & 1'($urandom), 1'b0, 8'hff);
    end
    rdchk(8'h1c, 8'(t_crc), 8'hff);
    rdchk(8'h18, 8'(t_al), 8'hff);
    rdchk(8'h20, 8'(t_drop), 8'hff);
    test_done();
  end
endmodule
